// ===== arcc_pkg.sv
// Constants for the converter reference, clock and coding control block
package arcc_pkg;

    // ------------------------------------------------------------------
    // Register map, word offsets on the plain register port
    // ------------------------------------------------------------------
    localparam logic [7:0] MODE_CTRL_OFS   = 8'h01;
    localparam logic [7:0] CODE_DATA_OFS   = 8'h04;
    localparam logic [7:0] STATUS_OFS      = 8'h05;
    localparam logic [7:0] CLK_IO_CTRL_OFS = 8'h06;
    localparam logic [7:0] CHAN_BASE_OFS   = 8'h10;
    localparam logic [7:0] SETUP0_OFS      = 8'h20;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] MODE_CTRL_RST = 16'h2000;
    localparam logic [15:0] SETUP0_RST    = 16'h1000;
    localparam logic [15:0] CHAN0_RST     = 16'h8001;
    localparam logic [15:0] CHAN_RST      = 16'h0001;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int REF_EN_BIT     = 15;
    localparam int CLK_SEL_HI     = 3;
    localparam int CLK_SEL_LO     = 2;
    localparam int REF_SEL_HI     = 5;
    localparam int REF_SEL_LO     = 4;
    localparam int POLARITY_BIT   = 12;
    localparam int CHAN_EN_BIT    = 15;
    localparam int CLK_OUT_EN_BIT = 0;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] CLK_INTERNAL = 2'h0;
    localparam logic [1:0] CLK_CRYSTAL  = 2'h1;
    localparam logic [1:0] CLK_EXTERNAL = 2'h2;
    localparam logic [1:0] REF_EXTERNAL = 2'h0;

    // ------------------------------------------------------------------
    // Clock figures
    // ------------------------------------------------------------------
    localparam int SRC_CLK_MHZ    = 16;
    localparam int MASTER_CLK_MHZ = 2;
    localparam int MCLK_DIV       = SRC_CLK_MHZ / MASTER_CLK_MHZ;
    localparam logic [2:0] MCLK_DIV_LAST = 3'(MCLK_DIV - 1);

endpackage

// ===== arcc_ctrl.sv
// Reference select, master clock selection, output coding and sequencing
`timescale 1ns/10ps
`default_nettype none

module arcc_ctrl #(
    parameter int CODE_W = 24,
    parameter int NUM_CH = 16,
    parameter int ADDR_W = 8
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [15:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [CODE_W-1:0]   reg_rdata,
    input  wire logic                osc_clk,
    input  wire logic                crystal_input_pin,
    input  wire logic                clk_io_in,
    output logic                     clk_io_out,
    output logic                     clk_io_oe,
    output logic                     mclk_tick,
    output logic                     reference_output_pin_en,
    output logic      [1:0]          reference_source_select,
    output logic      [3:0]          active_channel,
    input  wire logic                sample_valid,
    input  wire logic signed [CODE_W:0] sample_value,
    output logic      [CODE_W-1:0]   code_out,
    output logic      [3:0]          code_channel,
    output logic                     code_valid
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic       rst_meta;
    logic       rst_sync_n;

    // Asynchronous assert, two-flop release
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end
        else
        begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] converter_mode_control;
    logic [15:0] setup_config_zero;
    logic [15:0] clock_io_control;
    logic [15:0] chan_cfg [NUM_CH];

    wire wr_mode  = reg_wr && (reg_addr == arcc_pkg::MODE_CTRL_OFS);
    wire wr_setup = reg_wr && (reg_addr == arcc_pkg::SETUP0_OFS);
    wire wr_clkio = reg_wr && (reg_addr == arcc_pkg::CLK_IO_CTRL_OFS);
    wire wr_chan  = reg_wr && (reg_addr[ADDR_W-1:4] ==
                               arcc_pkg::CHAN_BASE_OFS[ADDR_W-1:4]);

    // Mode and setup registers; reset clears reference enable and
    // restores internal oscillator and external reference
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            converter_mode_control <= arcc_pkg::MODE_CTRL_RST;
            setup_config_zero      <= arcc_pkg::SETUP0_RST;
            clock_io_control       <= 16'h0000;
        end
        else
        begin
            if (wr_mode)
                converter_mode_control <= reg_wdata;
            if (wr_setup)
                setup_config_zero <= reg_wdata;
            if (wr_clkio)
                clock_io_control <= reg_wdata;
        end
    end

    // One channel register per entry
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_chan
            always_ff @(posedge clk or negedge rst_sync_n)
            begin
                if (!rst_sync_n)
                    chan_cfg[gi] <= (gi == 0) ? arcc_pkg::CHAN0_RST
                                              : arcc_pkg::CHAN_RST;
                else if (wr_chan && (reg_addr[3:0] == 4'(gi)))
                    chan_cfg[gi] <= reg_wdata;
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Reference control
    // ------------------------------------------------------------------
    wire [1:0] clk_sel = converter_mode_control[arcc_pkg::CLK_SEL_HI:
                                                arcc_pkg::CLK_SEL_LO];
    wire       bipolar = setup_config_zero[arcc_pkg::POLARITY_BIT];

    // Reference pin buffer follows the enable bit only
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            reference_output_pin_en <= 1'b0;
            reference_source_select <= arcc_pkg::REF_EXTERNAL;
        end
        else
        begin
            reference_output_pin_en <=
                converter_mode_control[arcc_pkg::REF_EN_BIT];
            reference_source_select <=
                setup_config_zero[arcc_pkg::REF_SEL_HI:
                                  arcc_pkg::REF_SEL_LO];
        end
    end

    // ------------------------------------------------------------------
    // Clock pins: three flops, change taken when last two agree
    // ------------------------------------------------------------------
    logic [2:0] osc_s;
    logic [2:0] xtal_s;
    logic [2:0] ext_s;
    logic       osc_f;
    logic       xtal_f;
    logic       ext_f;

    // A 16 MHz source sampled at 25 MHz loses edges; each level must last two samples to be taken
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            osc_s  <= 3'h0;
            xtal_s <= 3'h0;
            ext_s  <= 3'h0;
            osc_f  <= 1'b0;
            xtal_f <= 1'b0;
            ext_f  <= 1'b0;
        end
        else
        begin
            osc_s  <= {osc_s[1:0], osc_clk};
            xtal_s <= {xtal_s[1:0], crystal_input_pin};
            ext_s  <= {ext_s[1:0], clk_io_in};
            if (osc_s[1] == osc_s[2])
                osc_f <= osc_s[2];
            if (xtal_s[1] == xtal_s[2])
                xtal_f <= xtal_s[2];
            if (ext_s[1] == ext_s[2])
                ext_f <= ext_s[2];
        end
    end

    wire osc_rise  = osc_s[1] && osc_s[2] && !osc_f;
    wire xtal_rise = xtal_s[1] && xtal_s[2] && !xtal_f;
    wire ext_rise  = ext_s[1] && ext_s[2] && !ext_f;

    // ------------------------------------------------------------------
    // Master clock selection and division
    // ------------------------------------------------------------------
    logic [2:0] div_cnt;

    wire use_ext  = (clk_sel == arcc_pkg::CLK_EXTERNAL);
    wire use_xtal = (clk_sel == arcc_pkg::CLK_CRYSTAL);
    // Reserved encoding falls back to the oscillator
    wire src_rise = use_xtal ? xtal_rise : osc_rise;
    wire div_wrap = src_rise && (div_cnt == arcc_pkg::MCLK_DIV_LAST);
    wire next_tick = use_ext ? ext_rise : div_wrap;

    // Divide 16 MHz edges by eight; every rate downstream counts ticks
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            div_cnt   <= 3'h0;
            mclk_tick <= 1'b0;
        end
        else
        begin
            if (use_ext)
                div_cnt <= 3'h0;
            else if (src_rise)
                div_cnt <= div_cnt + 3'h1;
            mclk_tick <= next_tick;
        end
    end

    // Oscillator level out on the shared pin when asked and the internal oscillator is selected
    wire clk_out_req = clock_io_control[arcc_pkg::CLK_OUT_EN_BIT] &&
                       (clk_sel == arcc_pkg::CLK_INTERNAL);

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            clk_io_out <= 1'b0;
            clk_io_oe  <= 1'b0;
        end
        else
        begin
            clk_io_out <= osc_f;
            clk_io_oe  <= clk_out_req;
        end
    end

    // ------------------------------------------------------------------
    // Channel sequencer
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] ch_en;

    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_en
            assign ch_en[gi] = chan_cfg[gi][arcc_pkg::CHAN_EN_BIT];
        end
    endgenerate

    // Next enabled channel above cur, else wrap to lowest enabled
    function automatic logic [3:0] seq_next(input logic [NUM_CH-1:0] en,
                                            input logic [3:0] cur);
        logic [3:0] above;
        logic [3:0] low;
        logic       hit_above;
        logic       hit_low;
        above     = cur;
        low       = cur;
        hit_above = 1'b0;
        hit_low   = 1'b0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (en[i])
            begin
                low     = 4'(i);
                hit_low = 1'b1;
                if (4'(i) > cur)
                begin
                    above     = 4'(i);
                    hit_above = 1'b1;
                end
            end
        end
        return hit_above ? above : (hit_low ? low : cur);
    endfunction

    wire [3:0] next_channel = seq_next(ch_en, active_channel);

    // Step on each finished conversion; a disabled channel is left
    // at once so edits to the enables take effect without a stall
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            active_channel <= 4'h0;
        else if (sample_valid || !ch_en[active_channel])
            active_channel <= next_channel;
    end

    // ------------------------------------------------------------------
    // Output coding
    // ------------------------------------------------------------------
    localparam logic signed [CODE_W+1:0] FULL_S = (CODE_W+2)'((1 << CODE_W) - 1);
    localparam logic signed [CODE_W+1:0] MID_S  = (CODE_W+2)'(1 << (CODE_W - 1));

    // Sample is 2^N times the scaled input over the reference, the
    // voltage or current scaling being done ahead of this block
    wire signed [CODE_W+1:0] uni_raw = (CODE_W+2)'(sample_value);
    wire signed [CODE_W+1:0] bip_raw = MID_S +
                                       (CODE_W+2)'(sample_value >>> 1);
    wire signed [CODE_W+1:0] raw     = bipolar ? bip_raw : uni_raw;
    // Saturate; clips at all zeros and all ones in both formats
    wire [CODE_W-1:0] next_code = (raw < 0) ? '0 :
                                  (raw > FULL_S) ? '1 :
                                  raw[CODE_W-1:0];

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            code_out     <= '0;
            code_channel <= 4'h0;
            code_valid   <= 1'b0;
        end
        else
        begin
            code_valid <= sample_valid;
            if (sample_valid)
            begin
                code_out     <= next_code;
                code_channel <= active_channel;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read port: data stand in the cycle after the strobe only
    // ------------------------------------------------------------------
    logic [CODE_W-1:0] rd_mux;

    always_comb
    begin
        rd_mux = '0;
        if (reg_addr == arcc_pkg::MODE_CTRL_OFS)
            rd_mux = CODE_W'(converter_mode_control);
        else if (reg_addr == arcc_pkg::SETUP0_OFS)
            rd_mux = CODE_W'(setup_config_zero);
        else if (reg_addr == arcc_pkg::CLK_IO_CTRL_OFS)
            rd_mux = CODE_W'(clock_io_control);
        else if (reg_addr == arcc_pkg::CODE_DATA_OFS)
            rd_mux = code_out;
        else if (reg_addr == arcc_pkg::STATUS_OFS)
            rd_mux = CODE_W'({reference_output_pin_en, clk_io_oe,
                              code_channel, active_channel});
        else if (wr_chan || (reg_addr[ADDR_W-1:4] ==
                             arcc_pkg::CHAN_BASE_OFS[ADDR_W-1:4]))
            rd_mux = CODE_W'(chan_cfg[reg_addr[3:0]]);
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            reg_rdata <= '0;
        else
            reg_rdata <= reg_rd ? rd_mux : '0;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    property p_uni_mid;
        sample_valid && !bipolar && sample_value == (CODE_W+1)'(MID_S)
            |=> code_out == {1'b1, {(CODE_W-1){1'b0}}};
    endproperty
    a_uni_mid: assert property (p_uni_mid)
        else $error("unipolar midscale code wrong");

    property p_bip_zero;
        sample_valid && bipolar && sample_value == '0
            |=> code_valid && code_out == {1'b1, {(CODE_W-1){1'b0}}};
    endproperty
    a_bip_zero: assert property (p_bip_zero)
        else $error("bipolar zero code wrong");

    property p_uni_scale;
        sample_valid && !bipolar && sample_value >= 0 &&
        sample_value <= (CODE_W+1)'(FULL_S)
            |=> code_out == $past(sample_value[CODE_W-1:0]);
    endproperty
    a_uni_scale: assert property (p_uni_scale)
        else $error("unipolar code not proportional");

    property p_ref_sel;
        $changed(setup_config_zero[5:4])
            |=> reference_source_select == $past(setup_config_zero[5:4]);
    endproperty
    a_ref_sel: assert property (p_ref_sel)
        else $error("reference select not followed");

    property p_ref_en;
        wr_mode ##1 1'b1 |=>
            reference_output_pin_en == $past(reg_wdata[15], 2);
    endproperty
    a_ref_en: assert property (p_ref_en)
        else $error("reference output enable wrong");

    property p_ref_default;
        $rose(rst_sync_n) |-> !reference_output_pin_en &&
            reference_source_select == arcc_pkg::REF_EXTERNAL;
    endproperty
    a_ref_default: assert property (p_ref_default)
        else $error("reference reset state wrong");

    // A switch to the external pin may tick at once; that is allowed
    property p_div;
        $stable(clk_sel)[*3] ##0 (!use_ext && mclk_tick) |=>
            (!mclk_tick || use_ext)[*7];
    endproperty
    a_div: assert property (p_div)
        else $error("master clock divide wrong");

    property p_ext;
        use_ext && $past(use_ext) && ext_rise |=> mclk_tick;
    endproperty
    a_ext: assert property (p_ext)
        else $error("external clock not routed");

    property p_seq;
        sample_valid && ch_en[active_channel] |=>
            active_channel == $past(next_channel);
    endproperty
    a_seq: assert property (p_seq)
        else $error("sequencer order wrong");

    property p_rd_one;
        !reg_rd |=> reg_rdata == '0;
    endproperty
    a_rd_one: assert property (p_rd_one)
        else $error("read data outside slot");

    c_bipolar: cover property (sample_valid && bipolar);
    c_clk_out: cover property (clk_io_oe);
    c_wrap: cover property (sample_valid ##1 active_channel == 4'h0);
    c_ext: cover property (use_ext && mclk_tick);

endmodule

`default_nettype wire

// ===== arcc_src_model.sv
// Clock sources and shared clock pin seen from outside the control block
`timescale 1ns/10ps
`default_nettype none

module arcc_src_model #(
    parameter int OSC_NS  = 400,
    parameter int XTAL_NS = 320,
    parameter int EXT_NS  = 800
) (
    output logic      osc_clk,
    output logic      crystal_input_pin,
    output logic      clk_io_in,
    input  wire logic clk_io_out,
    input  wire logic clk_io_oe
);
    // ------------------------------------------------------------
    // Sources, slowed so every edge survives the synchroniser
    // ------------------------------------------------------------
    logic ext_clk;

    initial osc_clk = 1'b0;
    initial crystal_input_pin = 1'b0;
    initial ext_clk = 1'b0;
    always #(OSC_NS/2) osc_clk = ~osc_clk;
    always #(XTAL_NS/2) crystal_input_pin = ~crystal_input_pin;
    always #(EXT_NS/2) ext_clk = ~ext_clk;

    // Pin level: block drives it when enabled, else the outside clock
    assign clk_io_in = clk_io_oe ? clk_io_out : ext_clk;
endmodule
`default_nettype wire

// ===== tb.sv
// Self-checking testbench for the reference, clock and coding control
`timescale 1ns/10ps
`default_nettype none

module tb;
    // ------------------------------------------------------------
    // Signals, design and source model
    // ------------------------------------------------------------
    localparam int WIN = 1600;
    logic               clk, rst_n, reg_wr, reg_rd, sample_valid, bip;
    logic [7:0]         reg_addr;
    logic [15:0]        reg_wdata;
    logic [23:0]        reg_rdata, code_out;
    logic signed [24:0] sample_value;
    logic               osc_clk, crystal_input_pin, clk_io_in;
    logic               clk_io_out, clk_io_oe, mclk_tick, code_valid;
    logic               reference_output_pin_en;
    logic [1:0]         reference_source_select;
    logic [3:0]         active_channel, code_channel, last_ch, ch_a, ch_b;
    logic [23:0]        exp_q[$];
    logic [23:0]        last_code, prev_code;
    int                 failures, total_checks, n_hi;

    arcc_ctrl dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .osc_clk, .crystal_input_pin, .clk_io_in, .clk_io_out,
        .clk_io_oe, .mclk_tick, .reference_output_pin_en,
        .reference_source_select, .active_channel, .sample_valid,
        .sample_value, .code_out, .code_channel, .code_valid);
    arcc_src_model src (.osc_clk, .crystal_input_pin, .clk_io_in,
        .clk_io_out, .clk_io_oe);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("Checks made %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [7:0] a, input logic [23:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask

    // Ticks over a fixed window, one count of slack for phase
    task automatic ticks(input bit do_wr, input logic [1:0] sel,
                         input int per_ns, input int div);
        int n;
        int e;
        if (do_wr)
            wr(8'h01, {12'h000, sel, 2'h0});
        repeat (100) @(posedge clk);
        n = 0;
        e = WIN * 40 / per_ns / div;
        repeat (WIN)
        begin
            @(posedge clk);
            if (mclk_tick === 1'b1)
                n++;
        end
        check(24'((n >= e - 1 && n <= e + 1) ? e : n), 24'(e));
    endtask

    // Samples go back to back; the code is noted as each one is sent
    task automatic smp(input logic signed [24:0] v);
        logic signed [25:0] t;
        t = bip ? 26'sd8388608 + 26'(v >>> 1) : 26'(v);
        if (t < 0)
            t = 26'sd0;
        else if (t > 26'sd16777215)
            t = 26'sd16777215;
        exp_q.push_back(t[23:0]);
        @(posedge clk);
        sample_valid <= 1'b1;
        sample_value <= v;
    endtask

    task automatic batch;
        logic signed [24:0] edges [6];
        edges = '{25'sh0000000, 25'sh0800000, 25'sh0ffffff,
                  25'sh1ffffff, 25'sh1000000, 25'sh07fffff};
        foreach (edges[i])
            smp(edges[i]);
        repeat (8)
            smp(25'($urandom));
        @(posedge clk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Host side open-wire decision on the last channel pair
    task automatic owpair(input logic signed [24:0] a,
                          input logic signed [24:0] b, input bit flag);
        smp(a);
        smp(b);
        @(posedge clk);
        sample_valid <= 1'b0;
        repeat (3) @(posedge clk);
        check(24'(((last_code > prev_code) ? last_code - prev_code
                   : prev_code - last_code) > 24'd100000), 24'(flag));
    endtask

    // ------------------------------------------------------------
    // Result watcher: oldest note against each code that appears
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (code_valid === 1'b1)
        begin
            check(24'(exp_q.size() > 0), 24'h000001);
            if (exp_q.size() > 0)
                check(code_out, exp_q.pop_front());
            check(24'((code_channel == ch_a || code_channel == ch_b)
                  && code_channel != last_ch), 24'h000001);
            last_ch = code_channel;
            prev_code = last_code;
            last_code = code_out;
        end
    end

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        end_sim;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, sample_valid, bip} = 4'b0001;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        sample_value = 25'sh0;
        {last_ch, ch_a, ch_b} = {4'h7, 4'h0, 4'hf};
        failures = 0;
        total_checks = 0;
        void'($urandom(40));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdchk(8'h01, 24'h002000);
        rdchk(8'h20, 24'h001000);
        wr(8'h7f, 16'h3000);
        rdchk(8'h7f, 24'h000000);
        check(24'(reference_output_pin_en), 24'h0);
        check(24'(reference_source_select), 24'h0);
        ticks(1'b0, 2'h0, 400, arcc_pkg::MCLK_DIV);
        $display("Test reset defaults done");
        ticks(1'b1, 2'h1, 320, arcc_pkg::MCLK_DIV);
        ticks(1'b1, 2'h2, 800, 1);
        ticks(1'b1, 2'h0, 400, arcc_pkg::MCLK_DIV);
        $display("Test clock sources done");
        wr(8'h06, 16'h0001);
        repeat (3) @(posedge clk);
        check(24'(clk_io_oe), 24'h1);
        // Pin level follows the oscillator, high about half the time
        n_hi = 0;
        repeat (400)
        begin
            @(posedge clk);
            if (clk_io_out === 1'b1)
                n_hi++;
        end
        check(24'(n_hi >= 180 && n_hi <= 220), 24'h1);
        wr(8'h06, 16'h0000);
        repeat (3) @(posedge clk);
        check(24'(clk_io_oe), 24'h0);
        wr(8'h01, 16'h8000);
        repeat (2) @(posedge clk);
        check(24'(reference_output_pin_en), 24'h1);
        rdchk(8'h01, 24'h008000);
        wr(8'h01, 16'h0000);
        wr(8'h20, 16'h1020);
        repeat (2) @(posedge clk);
        check(24'(reference_output_pin_en), 24'h0);
        check(24'(reference_source_select), 24'h2);
        $display("Test reference and clock out done");
        wr(8'h10, 16'h8010);
        wr(8'h1f, 16'h8010);
        wr(8'h20, 16'h0000);
        bip = 1'b0;
        batch;
        wr(8'h20, 16'h1000);
        bip = 1'b1;
        batch;
        $display("Test single-ended coding done");
        wr(8'h10, 16'h0000);
        wr(8'h1f, 16'h0000);
        wr(8'h11, 16'h8001);
        wr(8'h12, 16'h8001);
        {last_ch, ch_a, ch_b} = {4'h7, 4'h1, 4'h2};
        repeat (3) @(posedge clk);
        check(24'(active_channel == 4'h1 || active_channel == 4'h2),
              24'h1);
        batch;
        owpair(25'sd461204, -25'sd461274, 1'b1);
        owpair(25'sd672006, 25'sd671938, 1'b0);
        check(24'(exp_q.size()), 24'h000000);
        $display("Test differential pairing done");
        end_sim;
    end
endmodule
`default_nettype wire
